/* File: src/inw_pkg.sv */
// Package for the interrupt nesting and wake-up qualifier
package inw_pkg;
    localparam int          NUM_SRC       = 8;
    localparam int          VEC_W         = 8;
    localparam logic [7:0]  VEC_SPURIOUS  = 8'h80;
    localparam logic [7:0]  VEC_PIN       = 8'hf4;
    localparam logic [7:0]  VEC_SRC_TOP   = 8'hf0;
    localparam logic [7:0]  VEC_STEP      = 8'h02;
    localparam logic [7:0]  VEC_RST       = 8'h80;
    localparam logic [1:0]  LEVEL_NONE    = 2'h0;
    localparam logic [1:0]  LEVEL_MASK    = 2'h1;
    localparam logic [1:0]  LEVEL_PIN     = 2'h2;

    typedef struct packed {
        logic maskI;
        logic maskX;
    } inw_flags_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] vecLow;
    } inw_vec_s;
endpackage

/* File: src/inw_core.sv */
// Nesting priority, vector supply and wake-up qualification
`timescale 1ns/10ps
// Notes on behaviour
// - A maskable service routine may be preempted by an unmasked pin request, or by any qualified maskable request once maskI is cleared, whatever its priority.
// - With the maskable mask still set, no maskable request preempts a running routine.
// - Every maskable request can wake the core from stop or wait.
// - Maskable wake-up qualification uses the same enable and mask conditions as run mode; the pin wake-up ignores maskX.
// - With the maskable mask set no maskable request produces a wake-up.
// - The stop wake-up path uses only asynchronous requests and no clocked logic.
// - The pin-level request wakes the core at any time, even with its mask set.
// - A masked pin-level wake-up gets no vector, so its routine is not entered.
// - After a masked pin-level wake-up the core resumes after the sleep instruction.
// - The higher vector address wins, and non-maskable requests outrank all maskable ones.
// - A request withdrawn before the vector fetch yields the spurious vector at base plus 0x80.
module inw_core #(
    parameter int NSRC = inw_pkg::NUM_SRC
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    // Requests and enables
    input  wire logic [NSRC-1:0]      srcReq,
    input  wire logic [NSRC-1:0]      srcEnable,
    input  wire logic                 pinLevelRequest_n,
    // Core side
    input  wire inw_pkg::inw_flags_s  cpuConditionFlags,
    input  wire logic                 vecFetch,
    output logic                      irqPending,
    output inw_pkg::inw_vec_s         vecOut,
    output logic                      resumeNoVector,
    output logic                      wakeUp
);
    import inw_pkg::*;

    logic [1:0]      pinSync;
    logic [NSRC-1:0] srcSync0;
    logic [NSRC-1:0] srcSync;
    logic            pinAsync;
    logic            pinReq;
    logic [NSRC-1:0] qualified;
    logic [NSRC-1:0] qualifiedAsync;
    logic            anyMaskable;
    logic            pinTaken;
    logic [7:0]      winVec;
    logic [1:0]      curLevel;
    logic            preempt;
    inw_vec_s        next_vecOut;

    // Lowest index is highest vector address
    function automatic logic [7:0] pick_vec(input logic [NSRC-1:0] q);
        logic [7:0] v;
        v = VEC_SPURIOUS;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (q[i]) begin
                v = VEC_SRC_TOP - 8'(i) * VEC_STEP;
            end
        end
        return v;
    endfunction

    // Wake path is raw gates so it works with every clock stopped
    assign pinAsync       = ~pinLevelRequest_n;
    assign qualifiedAsync = srcReq & srcEnable & {NSRC{~cpuConditionFlags.maskI}};
    assign wakeUp         = pinAsync | (|qualifiedAsync);

    assign pinReq      = pinSync[1];
    assign qualified   = srcSync & srcEnable & {NSRC{~cpuConditionFlags.maskI}};
    assign anyMaskable = |qualified;
    assign pinTaken    = pinReq & ~cpuConditionFlags.maskX;
    assign winVec      = pinTaken ? VEC_PIN : pick_vec(qualified);
    assign preempt     = (pinTaken & (curLevel != LEVEL_PIN)) | (anyMaskable & (curLevel == LEVEL_NONE));

    always_comb begin
        next_vecOut = vecOut;
        if (vecFetch) begin
            next_vecOut.valid  = 1'b1;
            next_vecOut.vecLow = winVec;
        end else begin
            next_vecOut.valid = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinSync  <= 2'h0;
            srcSync0 <= '0;
            srcSync  <= '0;
        end else begin
            pinSync  <= {pinSync[0], pinAsync};
            srcSync0 <= srcReq;
            srcSync  <= srcSync0;
        end
    end

    // Level tracks the class being served; clearing the mask reopens nesting
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            curLevel <= LEVEL_NONE;
        end else if (vecFetch) begin
            curLevel <= pinTaken ? LEVEL_PIN : (anyMaskable ? LEVEL_MASK : curLevel);
        end else if (curLevel == LEVEL_MASK && !cpuConditionFlags.maskI) begin
            curLevel <= LEVEL_NONE;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            vecOut         <= '{valid: 1'b0, vecLow: VEC_RST};
            irqPending     <= 1'b0;
            resumeNoVector <= 1'b0;
        end else begin
            vecOut         <= next_vecOut;
            irqPending     <= preempt;
            resumeNoVector <= pinReq & cpuConditionFlags.maskX;
        end
    end

    property p_masked_pin_no_vector;
        @(posedge core_clk) disable iff (!arst_n)
        (vecFetch && !pinTaken && !anyMaskable) |=> (vecOut.vecLow == 8'h80);
    endproperty
    a_masked_pin_no_vector: assert property (p_masked_pin_no_vector) else $error("spurious vector missing");

    property p_pin_wins;
        @(posedge core_clk) disable iff (!arst_n)
        (vecFetch && pinTaken) |=> (vecOut.valid && vecOut.vecLow == 8'hf4);
    endproperty
    a_pin_wins: assert property (p_pin_wins) else $error("pin request lost priority");

    property p_mask_blocks_wake;
        @(posedge core_clk) disable iff (!arst_n)
        (cpuConditionFlags.maskI && pinLevelRequest_n) |-> !wakeUp;
    endproperty
    a_mask_blocks_wake: assert property (p_mask_blocks_wake) else $error("masked wake-up");

    property p_pin_wakes;
        @(posedge core_clk) disable iff (!arst_n)
        !pinLevelRequest_n |-> wakeUp;
    endproperty
    a_pin_wakes: assert property (p_pin_wakes) else $error("pin did not wake");

    property p_no_nest_masked;
        @(posedge core_clk) disable iff (!arst_n)
        (curLevel == LEVEL_MASK && !pinTaken) |=> !irqPending;
    endproperty
    a_no_nest_masked: assert property (p_no_nest_masked) else $error("maskable nested while masked");

    property p_resume_masked;
        @(posedge core_clk) disable iff (!arst_n)
        (pinReq && cpuConditionFlags.maskX) |=> resumeNoVector;
    endproperty
    a_resume_masked: assert property (p_resume_masked) else $error("no resume flag");

    property p_unmask_nest;
        @(posedge core_clk) disable iff (!arst_n)
        (curLevel == LEVEL_MASK && !cpuConditionFlags.maskI && !vecFetch) |=> (curLevel == LEVEL_NONE);
    endproperty
    a_unmask_nest: assert property (p_unmask_nest) else $error("nesting not reopened");

    property p_wake_qual;
        @(posedge core_clk) disable iff (!arst_n)
        (|(srcReq & srcEnable) && !cpuConditionFlags.maskI) |-> wakeUp;
    endproperty
    a_wake_qual: assert property (p_wake_qual) else $error("qualified source did not wake");

    // A fetch already under way when a masked pin wakes must not enter its routine
    property p_pin_masked_vec;
        @(posedge core_clk) disable iff (!arst_n)
        (vecFetch && pinReq && cpuConditionFlags.maskX) |=> (vecOut.vecLow != VEC_PIN);
    endproperty
    a_pin_masked_vec: assert property (p_pin_masked_vec) else $error("masked pin got its vector");

    property p_fetch_answers;
        @(posedge core_clk) disable iff (!arst_n)
        vecFetch |=> vecOut.valid;
    endproperty
    a_fetch_answers: assert property (p_fetch_answers) else $error("fetch got no vector");

    property p_no_fetch_no_valid;
        @(posedge core_clk) disable iff (!arst_n)
        !vecFetch |=> !vecOut.valid;
    endproperty
    a_no_fetch_no_valid: assert property (p_no_fetch_no_valid) else $error("vector without fetch");

    property p_mask_no_pending;
        @(posedge core_clk) disable iff (!arst_n)
        (cpuConditionFlags.maskI && !pinTaken) |=> !irqPending;
    endproperty
    a_mask_no_pending: assert property (p_mask_no_pending) else $error("masked request pending");

    property p_unmasked_nest;
        @(posedge core_clk) disable iff (!arst_n)
        (anyMaskable && curLevel == LEVEL_NONE) |=> irqPending;
    endproperty
    a_unmasked_nest: assert property (p_unmasked_nest) else $error("unmasked request not pending");

    property p_pin_preempts;
        @(posedge core_clk) disable iff (!arst_n)
        (pinTaken && curLevel != LEVEL_PIN) |=> irqPending;
    endproperty
    a_pin_preempts: assert property (p_pin_preempts) else $error("pin request did not preempt");

    // No return signal exists, so the pin level leaves only through reset or a fetch won by a qualified maskable request
    property p_pin_level_holds;
        @(posedge core_clk) disable iff (!arst_n)
        (curLevel == LEVEL_PIN) |=> (curLevel == LEVEL_PIN);
    endproperty
    a_pin_level_holds: assert property (p_pin_level_holds) else $error("pin level dropped");

    property p_maskable_vec_range;
        @(posedge core_clk) disable iff (!arst_n)
        (vecFetch && !pinTaken && anyMaskable) |=> (vecOut.vecLow <= VEC_SRC_TOP && vecOut.vecLow > VEC_SPURIOUS);
    endproperty
    a_maskable_vec_range: assert property (p_maskable_vec_range) else $error("maskable vector out of range");

    property p_resume_clear;
        @(posedge core_clk) disable iff (!arst_n)
        (!pinReq || !cpuConditionFlags.maskX) |=> !resumeNoVector;
    endproperty
    a_resume_clear: assert property (p_resume_clear) else $error("stale resume flag");

    property p_enable_blocks_wake;
        @(posedge core_clk) disable iff (!arst_n)
        (pinLevelRequest_n && !(|(srcReq & srcEnable))) |-> !wakeUp;
    endproperty
    a_enable_blocks_wake: assert property (p_enable_blocks_wake) else $error("disabled source woke");
endmodule // inw_core

/* File: tb/inw_core_model.sv */
// Core-side model that fetches vectors and captures them
`timescale 1ns/10ps
module inw_core_model (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // Bench side
    input  wire logic              fetchGo,
    output logic [7:0]             lastVec,
    output logic                   gotVec,
    // Block side
    input  wire logic              resumeNoVector,
    input  wire inw_pkg::inw_vec_s vecOut,
    output logic                   vecFetch
);
    import inw_pkg::*;
    // Masked pin wake-up resumes in line, so no fetch is issued then
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            vecFetch <= 1'b0;
            lastVec  <= 8'h00;
            gotVec   <= 1'b0;
        end else begin
            vecFetch <= fetchGo & ~resumeNoVector;
            gotVec   <= vecOut.valid;
            lastVec  <= vecOut.valid ? vecOut.vecLow : lastVec;
        end
    end
endmodule // inw_core_model

/* File: tb/tb_inw_core.sv */
// Testbench for the nesting and wake-up qualifier
`timescale 1ns/10ps
module tb_inw_core;
    import inw_pkg::*;
    logic       core_clk = 1'b0, arst_n = 1'b0, pinLevelRequest_n = 1'b1, fetchGo = 1'b0;
    logic       vecFetch, irqPending, resumeNoVector, wakeUp, gotVec;
    logic [7:0] srcReq = 8'h00, srcEnable = 8'h00, lastVec, v;
    inw_flags_s flags = '{maskI: 1'b1, maskX: 1'b1};
    inw_vec_s   vecOut;
    int         n_mismatch = 0, n_compared = 0;
    always #20 core_clk = ~core_clk;
    inw_core i_inw_core (.core_clk(core_clk), .arst_n(arst_n), .srcReq(srcReq), .srcEnable(srcEnable),
        .pinLevelRequest_n(pinLevelRequest_n), .cpuConditionFlags(flags), .vecFetch(vecFetch),
        .irqPending(irqPending), .vecOut(vecOut), .resumeNoVector(resumeNoVector), .wakeUp(wakeUp));
    inw_core_model i_inw_core_model (.core_clk(core_clk), .arst_n(arst_n), .fetchGo(fetchGo),
        .lastVec(lastVec), .gotVec(gotVec), .resumeNoVector(resumeNoVector), .vecOut(vecOut), .vecFetch(vecFetch));
    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic put(input logic [7:0] req, input logic [7:0] en, input logic mi, input logic mx);
        @(posedge core_clk);
        srcReq    <= req;
        srcEnable <= en;
        flags     <= '{maskI: mi, maskX: mx};
        #1;
    endtask
    // Bounded wait for the captured vector
    task automatic fetch();
        @(posedge core_clk);
        fetchGo <= 1'b1;
        @(posedge core_clk);
        fetchGo <= 1'b0;
        #1;
        for (int i = 0; i < 8 && gotVec !== 1'b1; i++) cyc(1);
        if (gotVec !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
        v = lastVec;
    endtask
    task automatic t_wake();
        for (int i = 0; i < 8; i++) begin
            put(8'h01 << i, 8'hff, 1'b0, 1'b1);
            chk(wakeUp, 1'b1);
            put(8'h01 << i, ~(8'h01 << i), 1'b0, 1'b1);
            chk(wakeUp, 1'b0);
            put(8'h01 << i, 8'hff, 1'b1, 1'b0);
            chk(wakeUp, 1'b0);
        end
    endtask
    // Lower sources stay pending so the winner must be picked
    task automatic t_prio();
        for (int i = 0; i < 8; i++) begin
            put(8'hff << i, 8'hff, 1'b0, 1'b1);
            cyc(3);
            fetch();
            chk(v, VEC_SRC_TOP - 8'(2 * i));
            put(8'h00, 8'hff, 1'b1, 1'b1);
            put(8'h00, 8'hff, 1'b0, 1'b1);
            cyc(3);
        end
    endtask
    task automatic t_nest();
        put(8'h02, 8'hff, 1'b0, 1'b1);
        cyc(3);
        fetch();
        chk(v, VEC_SRC_TOP - VEC_STEP);
        put(8'h03, 8'hff, 1'b1, 1'b1);
        cyc(3);
        chk(irqPending, 1'b0);
        put(8'h03, 8'hff, 1'b0, 1'b1);
        cyc(3);
        chk(irqPending, 1'b1);
        fetch();
        chk(v, VEC_SRC_TOP);
        put(8'h01, 8'hff, 1'b1, 1'b1);
        put(8'h01, 8'hff, 1'b0, 1'b1);
        cyc(3);
        put(8'h00, 8'hff, 1'b0, 1'b1);
        cyc(3);
        fetch();
        chk(v, VEC_SPURIOUS);
    endtask
    // Pin level stays held until reset or a fetch won by a maskable request, so this runs just before t_reset
    task automatic t_pin();
        put(8'h00, 8'hff, 1'b1, 1'b1);
        @(posedge core_clk);
        pinLevelRequest_n <= 1'b0;
        #1;
        chk(wakeUp, 1'b1);
        fetch();
        chk(v, VEC_SPURIOUS);
        chk(resumeNoVector, 1'b1);
        @(posedge core_clk);
        fetchGo <= 1'b1;
        @(posedge core_clk);
        fetchGo <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            cyc(1);
            chk(gotVec, 1'b0);
        end
        put(8'h01, 8'hff, 1'b0, 1'b0);
        cyc(3);
        chk(resumeNoVector, 1'b0);
        chk(irqPending, 1'b1);
        fetch();
        chk(v, VEC_PIN);
        cyc(2);
        chk(irqPending, 1'b0);
    endtask
    // Mid-run reset must drop the held pin level and the registered outputs
    task automatic t_reset();
        put(8'h00, 8'hff, 1'b1, 1'b1);
        @(posedge core_clk);
        pinLevelRequest_n <= 1'b1;
        arst_n            <= 1'b0;
        cyc(2);
        chk(irqPending, 1'b0);
        chk(resumeNoVector, 1'b0);
        chk(vecOut.vecLow, VEC_RST);
        chk(wakeUp, 1'b0);
        @(posedge core_clk);
        arst_n <= 1'b1;
        #1;
        put(8'h02, 8'hff, 1'b0, 1'b1);
        cyc(4);
        chk(irqPending, 1'b1);
        fetch();
        chk(v, VEC_SRC_TOP - VEC_STEP);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        cyc(1);
        chk(vecOut.vecLow, VEC_RST);
        t_wake();
        t_prio();
        t_nest();
        t_pin();
        t_reset();
        wrap_up();
    end
endmodule // tb_inw_core
